// ---- inc/spc_cfg.svh ----
// Register indices, field positions, reset values and dividers of the port.
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SPC_IDX_CONTROL 10'h098
`define SPC_IDX_DATA 10'h099
`define SPC_IDX_ADDR 10'h0A9
`define SPC_IDX_MASK 10'h0B9
`define SPC_IDX_MODE 10'h0C0
`define SPC_IDX_BAUD 10'h0C1
`define SPC_IDX_BITOP 10'h0C2

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SPC_B_FE_SM0 7
`define SPC_B_SM1 6
`define SPC_B_SM2 5
`define SPC_B_REN 4
`define SPC_B_TB8 3
`define SPC_B_RB8 2
`define SPC_B_TI 1
`define SPC_B_RI 0
`define SPC_B_DRATE 7
`define SPC_B_FSEL 6
`define SPC_B_X2 0
`define SPC_BITOP_VAL 3

// ----------------------------------------------------------------------
// Reset values, bit-time dividers in clock cycles and frame lengths in bits
// ----------------------------------------------------------------------
`define SPC_RST_BYTE 8'h00
`define SPC_RST_BAUD 16'h043D
`define SPC_DIV_SHIFT 16'h000C
`define SPC_DIV_SHIFT_X2 16'h0006
`define SPC_DIV_UART9 16'h0040
`define SPC_DIV_UART9_DR 16'h0020
`define SPC_LEN_SHIFT 4'h8
`define SPC_LEN_UART8 4'hA
`define SPC_LEN_UART9 4'hB

`endif

// ---- inc/spc_pkg.sv ----
// Types shared by the serial port control block.
package spc_pkg;
    // Serial modes in the order of the two mode-select bits.
    typedef enum logic [1:0] {
        SPC_MODE_SHIFT,
        SPC_MODE_UART8,
        SPC_MODE_UART9F,
        SPC_MODE_UART9V
    } spc_mode_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spc_rx_t;
    typedef logic [15:0] spc_period_t;
endpackage : spc_pkg

// ---- design/spc_bit_timer.sv ----
// Bit-time divider giving one-cycle end and middle pulses.
`timescale 1ns/100ps
module spc_bit_timer #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic restart,
    input wire logic [W-1:0] period,
    output logic tick,
    output logic mid
);
    logic [W-1:0] cnt_r;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // A restart aligns the bit grid to the start of a frame.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else if (restart || tick) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Pulses are combinational so they line up with the counter value.
    assign tick = !restart && (cnt_r == period - 1'b1);
    assign mid = !restart && (cnt_r == (period >> 1));
endmodule : spc_bit_timer

// ---- design/spc_top.sv ----
// Serial port control, status, address match and data buffer over APB.
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`include "spc_cfg.svh"

module spc_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic txd,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe
);
    import spc_pkg::*;

    logic sm0_r, sm1_r, sm2_r, ren_r, tb8_r, rb8_r, ti_r, ri_r, fe_r;
    logic drate_r, fsel_r, x2_r;
    logic [7:0] slave_address_r, smask_r, rxbuf_r;
    logic [15:0] baud_r;
    logic [31:0] prdata_r;
    logic [9:0] idx;
    logic wr, mapped, ctl_we, data_we;
    logic [7:0] ctl_rd, ctl_wv;
    spc_mode_t mode;
    spc_period_t period;
    logic nine_bit;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // Zero wait states: read data is captured in the setup cycle.
    assign idx = paddr[11:2];
    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    assign mapped = idx == `SPC_IDX_CONTROL || idx == `SPC_IDX_DATA ||
        idx == `SPC_IDX_ADDR || idx == `SPC_IDX_MASK ||
        idx == `SPC_IDX_MODE || idx == `SPC_IDX_BAUD ||
        idx == `SPC_IDX_BITOP;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_r;

    // Control read view; bit 7 is shared between two meanings.
    assign ctl_rd = {fsel_r ? fe_r : sm0_r, sm1_r, sm2_r, ren_r,
        tb8_r, rb8_r, ti_r, ri_r};

    // Whole byte writes or single bit writes through the bit alias.
    always_comb begin
        ctl_wv = ctl_rd;
        ctl_we = 1'b0;
        if (wr && idx == `SPC_IDX_CONTROL) begin
            ctl_wv = pwdata[7:0];
            ctl_we = 1'b1;
        end else if (wr && idx == `SPC_IDX_BITOP) begin
            ctl_wv[pwdata[2:0]] = pwdata[`SPC_BITOP_VAL];
            ctl_we = 1'b1;
        end
    end
    assign data_we = wr && idx == `SPC_IDX_DATA;

    // Read mux; the bit alias and unmapped words read as zero.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_r <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (idx)
                `SPC_IDX_CONTROL: prdata_r <= {24'h000000, ctl_rd};
                `SPC_IDX_DATA: prdata_r <= {24'h000000, rxbuf_r};
                `SPC_IDX_ADDR: prdata_r <= {24'h000000, slave_address_r};
                `SPC_IDX_MASK: prdata_r <= {24'h000000, smask_r};
                `SPC_IDX_MODE: prdata_r <= {24'h000000, drate_r, fsel_r,
                    5'h00, x2_r};
                `SPC_IDX_BAUD: prdata_r <= {16'h0000, baud_r};
                default: prdata_r <= '0;
            endcase
        end
    end

    // Byte-only registers: address, mask, mode and baud reload.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slave_address_r <= `SPC_RST_BYTE;
            smask_r <= `SPC_RST_BYTE;
            drate_r <= 1'b0;
            fsel_r <= 1'b0;
            x2_r <= 1'b0;
            baud_r <= `SPC_RST_BAUD;
        end else if (wr) begin
            if (idx == `SPC_IDX_ADDR) slave_address_r <= pwdata[7:0];
            if (idx == `SPC_IDX_MASK) smask_r <= pwdata[7:0];
            if (idx == `SPC_IDX_MODE) begin
                drate_r <= pwdata[`SPC_B_DRATE];
                fsel_r <= pwdata[`SPC_B_FSEL];
                x2_r <= pwdata[`SPC_B_X2];
            end
            if (idx == `SPC_IDX_BAUD) baud_r <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Mode decode and bit time
    // ------------------------------------------------------------------
    assign mode = spc_mode_t'({sm0_r, sm1_r});
    assign nine_bit = mode == SPC_MODE_UART9F || mode == SPC_MODE_UART9V;

    // The double rate bit halves the bit time in every UART mode.
    always_comb begin
        case (mode)
            SPC_MODE_SHIFT: period = x2_r ? `SPC_DIV_SHIFT_X2
                : `SPC_DIV_SHIFT;
            SPC_MODE_UART9F: period = drate_r ? `SPC_DIV_UART9_DR
                : `SPC_DIV_UART9;
            default: period = drate_r ? (baud_r >> 1) : baud_r;
        endcase
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    logic tx_busy_r, tx_tick, tx_mid, tx_start, tx_ti;
    logic [10:0] tx_sh_r;
    logic [3:0] tx_cnt_r, tx_len_r;
    logic sclk_r;

    // A write while a frame is in flight is dropped, not queued.
    assign tx_start = data_we && !tx_busy_r;

    spc_bit_timer #(.W(16)) u_tx_timer (
        .clk(clk),
        .rst_b(rst_b),
        .restart(tx_start),
        .period(period),
        .tick(tx_tick),
        .mid(tx_mid)
    );

    // Frames shift out LSB first: start, data, ninth bit in the nine-bit modes, stop; shift mode sends data only.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_busy_r <= 1'b0;
            tx_sh_r <= '1;
            tx_cnt_r <= '0;
            tx_len_r <= `SPC_LEN_SHIFT;
        end else if (tx_start) begin
            tx_busy_r <= 1'b1;
            tx_cnt_r <= '0;
            case (mode)
                SPC_MODE_SHIFT: begin
                    tx_sh_r <= {3'h7, pwdata[7:0]};
                    tx_len_r <= `SPC_LEN_SHIFT;
                end
                SPC_MODE_UART8: begin
                    tx_sh_r <= {2'h3, pwdata[7:0], 1'b0};
                    tx_len_r <= `SPC_LEN_UART8;
                end
                default: begin
                    tx_sh_r <= {1'b1, tb8_r, pwdata[7:0], 1'b0};
                    tx_len_r <= `SPC_LEN_UART9;
                end
            endcase
        end else if (tx_busy_r && tx_tick) begin
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
            tx_cnt_r <= tx_cnt_r + 1'b1;
            if (tx_cnt_r + 1'b1 == tx_len_r) tx_busy_r <= 1'b0;
        end
    end

    // Flag at the end of bit 8 in shift mode, else entering the stop bit.
    assign tx_ti = tx_busy_r && tx_tick && (mode == SPC_MODE_SHIFT ?
        tx_cnt_r == `SPC_LEN_SHIFT - 4'h1 :
        tx_cnt_r == tx_len_r - 4'h2);

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    spc_rx_t rx_st_r;
    logic rx_tick, rx_mid, rx_restart, rx_shift0, rx_ri, rx_fe;
    logic [8:0] rx_sh_r, sh_nxt;
    logic [3:0] rx_cnt_r;
    logic [7:0] rx_byte_r, cand_byte, bcast;
    logic rx_ninth_r, cand_ninth, deliver, accept, addr_hit;

    // Shift mode reception needs REN set and the receive flag clear.
    assign rx_restart = rx_st_r == RX_IDLE && ren_r &&
        (mode == SPC_MODE_SHIFT ? !ri_r && !tx_busy_r && !tx_start
        : !rxd_in);
    assign rx_shift0 = mode == SPC_MODE_SHIFT;

    spc_bit_timer #(.W(16)) u_rx_timer (
        .clk(clk),
        .rst_b(rst_b),
        .restart(rx_restart),
        .period(period),
        .tick(rx_tick),
        .mid(rx_mid)
    );

    assign sh_nxt = {rxd_in, rx_sh_r[8:1]};
    assign cand_byte = nine_bit ? sh_nxt[7:0] : sh_nxt[8:1];
    assign cand_ninth = sh_nxt[8];

    // Mask zeros are don't-care in the own compare; broadcast ignores only bits zero in both address and mask.
    assign bcast = slave_address_r | smask_r;
    assign addr_hit = (((rx_byte_r ^ slave_address_r) & smask_r) == 8'h00) ||
        ((rx_byte_r & bcast) == bcast);

    // Delivery point: middle of the stop bit in both cases, with the framing check only when fsel_r is set.
    assign deliver = rx_st_r == RX_STOP && rx_mid && !rx_shift0 &&
        fsel_r;
    logic deliver_early;
    assign deliver_early = rx_st_r == RX_STOP && rx_mid && !rx_shift0 &&
        !fsel_r;
    // Filtering only in the nine-bit modes; RI must be clear to load.
    assign accept = (deliver || deliver_early) && !ri_r &&
        (!(sm2_r && nine_bit) || (rx_ninth_r && addr_hit));
    assign rx_fe = deliver && !rxd_in;
    assign rx_ri = accept || (rx_shift0 && rx_st_r == RX_DATA && rx_tick &&
        rx_cnt_r == `SPC_LEN_SHIFT);

    // The byte is captured at the last data bit and delivered from the
    // stop state, so the match logic sees a stable register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_st_r <= RX_IDLE;
            rx_sh_r <= '0;
            rx_cnt_r <= '0;
            rx_byte_r <= '0;
            rx_ninth_r <= 1'b0;
        end else if (!ren_r) begin
            rx_st_r <= RX_IDLE;
        end else begin
            case (rx_st_r)
                RX_IDLE: begin
                    rx_cnt_r <= '0;
                    if (rx_restart) begin
                        rx_st_r <= rx_shift0 ? RX_DATA : RX_START;
                    end
                end
                RX_START: begin
                    if (rx_mid) rx_st_r <= rxd_in ? RX_IDLE : RX_DATA;
                end
                RX_DATA: begin
                    if (rx_mid) begin
                        rx_sh_r <= sh_nxt;
                        rx_cnt_r <= rx_cnt_r + 1'b1;
                    end
                    if (rx_shift0) begin
                        if (rx_mid && rx_cnt_r == `SPC_LEN_SHIFT - 4'h1) begin
                            rx_byte_r <= sh_nxt[8:1];
                        end
                        if (rx_tick && rx_cnt_r == `SPC_LEN_SHIFT) begin
                            rx_st_r <= RX_IDLE;
                        end
                    end else if (rx_mid && rx_cnt_r ==
                            (nine_bit ? 4'h8 : 4'h7)) begin
                        rx_byte_r <= cand_byte;
                        rx_ninth_r <= cand_ninth;
                        rx_st_r <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_mid) rx_st_r <= RX_IDLE;
                end
                default: rx_st_r <= RX_IDLE;
            endcase
        end
    end

    // Shift clock follows only a running timer; an idle one would glitch it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_r <= 1'b1;
        end else if (tx_start || rx_restart || (tx_busy_r && tx_tick) ||
                (rx_st_r == RX_DATA && rx_tick)) begin
            sclk_r <= 1'b0;
        end else if ((tx_busy_r && tx_mid) ||
                (rx_st_r == RX_DATA && rx_mid)) begin
            sclk_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Control register and data buffer
    // ------------------------------------------------------------------
    // Hardware sets win over a software clear in the same cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {sm0_r, sm1_r, sm2_r, ren_r, tb8_r} <= 5'h00;
            {rb8_r, ti_r, ri_r, fe_r} <= 4'h0;
        end else begin
            if (ctl_we) begin
                if (fsel_r) fe_r <= ctl_wv[`SPC_B_FE_SM0];
                else sm0_r <= ctl_wv[`SPC_B_FE_SM0];
                sm1_r <= ctl_wv[`SPC_B_SM1];
                sm2_r <= ctl_wv[`SPC_B_SM2];
                ren_r <= ctl_wv[`SPC_B_REN];
                tb8_r <= ctl_wv[`SPC_B_TB8];
                rb8_r <= ctl_wv[`SPC_B_RB8];
                ti_r <= ctl_wv[`SPC_B_TI];
                ri_r <= ctl_wv[`SPC_B_RI];
            end
            if (rx_fe) fe_r <= 1'b1;
            if (tx_ti) ti_r <= 1'b1;
            if (rx_ri) ri_r <= 1'b1;
            if (accept && nine_bit) rb8_r <= rx_ninth_r;
        end
    end

    // Receive buffer keeps the last accepted byte.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxbuf_r <= `SPC_RST_BYTE;
        end else if (accept || (rx_ri && rx_shift0)) begin
            rxbuf_r <= rx_byte_r;
        end
    end

    // ------------------------------------------------------------------
    // Line pins
    // ------------------------------------------------------------------
    // Shift mode: data on the two-way pin, shift clock on the output pin.
    assign txd = rx_shift0 ? ((tx_busy_r || rx_st_r == RX_DATA) ? sclk_r
        : 1'b1) : tx_sh_r[0];
    assign rxd_oe = rx_shift0 && tx_busy_r;
    assign rxd_out = tx_sh_r[0];
endmodule : spc_top

// ---- test/spc_checker.sv ----
// Port-level checker of the serial port control block.
`timescale 1ns/100ps
`include "spc_cfg.svh"
module spc_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic txd,
    input wire logic rxd_in,
    input wire logic rxd_out,
    input wire logic rxd_oe
);
    logic [9:0] idx;
    logic acc;
    logic mapped;
    logic [7:0] adr_r;
    logic [7:0] msk_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // --------------------------------------------------------------
    // Decode helpers
    // --------------------------------------------------------------
    // The index decode is repeated here so a slip in the design shows.
    assign idx = paddr[11:2];
    assign acc = psel && penable;
    assign mapped = idx inside {`SPC_IDX_CONTROL, `SPC_IDX_DATA,
        `SPC_IDX_ADDR, `SPC_IDX_MASK, `SPC_IDX_MODE, `SPC_IDX_BAUD,
        `SPC_IDX_BITOP};
    // Shadows of the address and mask registers, updated at write completion.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            adr_r <= 8'h00;
            msk_r <= 8'h00;
        end else if (acc && pwrite && idx == `SPC_IDX_ADDR) begin
            adr_r <= pwdata[7:0];
        end else if (acc && pwrite && idx == `SPC_IDX_MASK) begin
            msk_r <= pwdata[7:0];
        end
    end
    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_read;
        acc && !pwrite;
    endsequence
    a_ready_no_wait: assert property (s_setup ##1 acc |-> pready)
        else $error("access phase without ready");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access refused");
    a_unmapped_zero: assert property (s_read and !mapped |-> prdata == 0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (s_read and mapped |->
        (idx == `SPC_IDX_BAUD ? prdata[31:16] == 0 : prdata[31:8] == 0))
        else $error("unused read bits not zero");
    a_addr_readback: assert property (
        s_read and idx == `SPC_IDX_ADDR |-> prdata[7:0] == adr_r)
        else $error("slave address readback wrong");
    a_mask_readback: assert property (
        s_read and idx == `SPC_IDX_MASK |-> prdata[7:0] == msk_r)
        else $error("address mask readback wrong");
    a_line_reset: assert property ($rose(rst_b) |-> txd && !rxd_oe)
        else $error("serial lines not idle after reset");
endmodule : spc_checker

bind spc_top spc_checker u_chk (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe));

// ---- test/spc_remote.sv ----
// Remote serial node that sends whole frames into the receive pin.
`timescale 1ns/100ps
module spc_remote (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic [11:0] frame,
    input wire logic [3:0] nbits,
    input wire logic [15:0] period,
    output logic line,
    output logic busy
);
    logic [11:0] sh_r;
    logic [3:0] left_r;
    logic [15:0] cnt_r;
    // The line idles high, as a pulled-up wire does between frames.
    assign busy = (left_r != 4'h0);
    assign line = busy ? sh_r[0] : 1'b1;
    // Bits leave LSB first, each held for one period of clocks.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_r <= 12'hFFF;
            left_r <= 4'h0;
            cnt_r <= 16'h0000;
        end else if (!busy && go) begin
            sh_r <= frame;
            left_r <= nbits;
            cnt_r <= period - 16'h0001;
        end else if (busy && cnt_r == 16'h0000) begin
            sh_r <= {1'b1, sh_r[11:1]};
            left_r <= left_r - 4'h1;
            cnt_r <= period - 16'h0001;
        end else if (busy) begin
            cnt_r <= cnt_r - 16'h0001;
        end
    end
endmodule : spc_remote

// ---- test/tb.sv ----
// Self-checking testbench of the serial port control block.
`timescale 1ns/100ps
`include "spc_cfg.svh"
module tb;
    import spc_pkg::*;
    typedef struct {
        logic wr;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] exp;
        logic err;
    } spc_row_t;
    localparam logic [11:0] ad_ctl = {`SPC_IDX_CONTROL, 2'b00};
    localparam logic [11:0] ad_dat = {`SPC_IDX_DATA, 2'b00};
    localparam logic [11:0] ad_adr = {`SPC_IDX_ADDR, 2'b00};
    localparam logic [11:0] ad_msk = {`SPC_IDX_MASK, 2'b00};
    localparam logic [11:0] ad_mod = {`SPC_IDX_MODE, 2'b00};
    localparam logic [11:0] ad_baud = {`SPC_IDX_BAUD, 2'b00};
    localparam logic [11:0] ad_bit = {`SPC_IDX_BITOP, 2'b00};
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic txd, rxd, rxd_out, rxd_oe, go, busy, se;
    logic [11:0] frame;
    logic [3:0] nbits;
    logic [15:0] period;
    int n_errors, comparisons, cycles, k;
    spc_row_t rows [10];
    spc_top uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .txd(txd), .rxd_in(rxd),
        .rxd_out(rxd_out), .rxd_oe(rxd_oe));
    spc_remote rem (.clk(clk), .rst_b(rst_b), .go(go), .frame(frame),
        .nbits(nbits), .period(period), .line(rxd), .busy(busy));
    // ------------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // The ceiling leaves ample slack over the frames sent below.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One APB transfer; the request is held until ready is sampled high.
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Sends one frame from the remote node and waits until it is over.
    task automatic send(logic [11:0] f, logic [3:0] n, logic [15:0] p);
        @(posedge clk);
        frame <= f;
        nbits <= n;
        period <= p;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        // Busy rises only after the load edge, so look one edge later.
        @(posedge clk);
        while (busy) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask : send
    task automatic rdchk(string nm, logic [11:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdchk
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, go} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        frame = 12'hFFF;
        nbits = 4'h0;
        period = 16'h0010;
        rst_b = 1'b0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rows = '{'{0, ad_ctl, 0, 0, 0}, '{0, ad_dat, 0, 0, 0},
            '{0, ad_adr, 0, 0, 0}, '{0, ad_msk, 0, 0, 0},
            '{1, ad_adr, 32'hA5, 0, 0}, '{0, ad_adr, 0, 32'hA5, 0},
            '{1, ad_msk, 32'h3C, 0, 0}, '{0, ad_msk, 0, 32'h3C, 0},
            '{0, 12'hFFC, 0, 0, 1}, '{1, 12'hFFC, 32'h1, 0, 1}};
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) chk("rdata", rows[i].exp, rd);
            chk("slverr", {31'h0, rows[i].err}, {31'h0, se});
        end
        // 8-bit UART send at 16 clocks a bit, LSB first.
        apb(1'b1, ad_baud, 32'h10);
        apb(1'b1, ad_ctl, 32'h40);
        apb(1'b1, ad_dat, 32'h5A);
        k = 0;
        while (txd === 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        repeat (8) @(negedge clk);
        chk("start", 0, {31'h0, txd});
        for (int i = 0; i < 9; i++) begin
            repeat (16) @(negedge clk);
            chk("txbit", (i < 8) ? 32'(8'h5A >> i) & 1 : 1,
                {31'h0, txd});
        end
        chk("oe", 0, {31'h0, rxd_oe});
        rdchk("ti", ad_ctl, 32'h42);
        // 9-bit receive at double rate with address filtering.
        apb(1'b1, ad_adr, 32'h56);
        apb(1'b1, ad_msk, 32'hFC);
        apb(1'b1, ad_mod, 32'h80);
        apb(1'b1, ad_ctl, 32'hB0);
        send({3'b110, 8'h56, 1'b0}, 4'hB, 16'h0020);
        rdchk("ri_data", ad_ctl, 32'hB0);
        send({3'b111, 8'h57, 1'b0}, 4'hB, 16'h0020);
        rdchk("ri_own", ad_ctl, 32'hB5);
        rdchk("rx_byte", ad_dat, 32'h57);
        apb(1'b1, ad_ctl, 32'hB0);
        send({3'b111, 8'hFF, 1'b0}, 4'hB, 16'h0020);
        rdchk("rx_bcast", ad_dat, 32'hFF);
        apb(1'b1, ad_ctl, 32'hB0);
        send({3'b111, 8'h12, 1'b0}, 4'hB, 16'h0020);
        apb(1'b0, ad_ctl, 32'h0);
        chk("ri_miss", 0, rd & 32'h1);
        // Framing check: a bad stop sets the flag and a good one keeps it.
        // Mode bit zero is cleared before bit 7 turns into the error flag.
        apb(1'b1, ad_ctl, 32'h50);
        apb(1'b1, ad_mod, 32'h40);
        send({2'b10, 8'h33, 1'b0}, 4'hA, 16'h0010);
        apb(1'b0, ad_ctl, 32'h0);
        chk("fe_set", 32'h80, rd & 32'h80);
        apb(1'b1, ad_bit, 32'h00);
        send({2'b11, 8'h44, 1'b0}, 4'hA, 16'h0010);
        rdchk("fe_kept", ad_ctl, 32'hD1);
        rdchk("rx_good", ad_dat, 32'h44);
        apb(1'b1, ad_ctl, 32'h40);
        rdchk("fe_clear", ad_ctl, 32'h40);
        send({2'b11, 8'h99, 1'b0}, 4'hA, 16'h0010);
        rdchk("ren_off", ad_ctl, 32'h40);
        rdchk("ren_data", ad_dat, 32'h44);
        // Shift mode send: bits of twelve clocks, clock low then high.
        apb(1'b1, ad_mod, 32'h00);
        apb(1'b1, ad_ctl, 32'h00);
        apb(1'b1, ad_dat, 32'hC3);
        repeat (5) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            chk("sh_data", 32'(8'hC3 >> i) & 1, {31'h0, rxd_out});
            chk("sh_oe", 1, {31'h0, rxd_oe});
            chk("sh_clk_lo", 0, {31'h0, txd});
            repeat (6) @(negedge clk);
            chk("sh_clk_hi", 1, {31'h0, txd});
            repeat (5) @(negedge clk);
        end
        rdchk("sh_ti", ad_ctl, 32'h02);
        tally_and_finish();
    end
endmodule : tb
